/* File: logic/afc_flow_ctrl.sv */
// Automatic receive FIFO flow controller: pause frames in full duplex, jamming in half duplex.
`timescale 1ns/1ps
`include "afc_regs.svh"
module afc_flow_ctrl import afc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata_q,
	// MAC status
	input wire logic txEnable,
	input wire logic fullDuplex,
	input wire logic speed10,
	input wire logic [15:0] pauseTimeValue,
	input wire logic [13:0] rxFifoBytes,
	// Receive frame indications
	input wire logic rxPreamble,
	input wire logic rxAddrValid,
	input wire logic rxMulticast,
	input wire logic rxBroadcast,
	input wire logic rxOwnAddress,
	// Pause and jam requests to the MAC
	output logic pauseReq_q,
	output logic [15:0] pauseTime_q,
	input wire logic pauseAck,
	output logic jam_q
);
	logic [31:0] cfg_q, cfg_d;
	logic [31:0] rdata_d;
	afc_state_e state_q, state_d;
	logic pauseReq_d;
	logic [15:0] pauseTime_d;
	logic jam_d;
	logic pauseSent_q, pauseSent_d;
	logic [13:0] hiBytes, loBytes;
	logic aboveHi, belowLo, anyEnabled, qualify, jamStart, timerBusy;
	logic [7:0] hiLevel, loLevel;
	logic [3:0] durCode;
	logic qualAny, qualMcast, qualBcast, qualOwn;

	// -----------------------------------------------------------------
	// Configuration register
	// -----------------------------------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		if (regWrite && regAddr == `AUTO_FLOW_CONTROL_CONFIG_OFFSET) begin
			cfg_d = regWdata & `AUTO_FLOW_CONTROL_CONFIG_WMASK;
		end
		// Unmapped reads return zero; reserved bits are never stored.
		// Read data is registered and held until the next read, so it may be taken late.
		rdata_d = regRdata_q;
		if (regRead) begin
			rdata_d = (regAddr == `AUTO_FLOW_CONTROL_CONFIG_OFFSET) ? cfg_q : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg_q <= `AUTO_FLOW_CONTROL_CONFIG_RESET;
			regRdata_q <= 32'h0000_0000;
		end else begin
			cfg_q <= cfg_d;
			regRdata_q <= rdata_d;
		end
	end

	// -----------------------------------------------------------------
	// Field decode
	// -----------------------------------------------------------------
	// Each field is named once here; later terms use these names, except the full-duplex
	// pause condition, which still slices the any-frame bit from the raw configuration word.
	always_comb begin
		hiLevel = cfg_q[`FLOW_HIGH_THRESHOLD_MSB:`FLOW_HIGH_THRESHOLD_LSB];
		loLevel = cfg_q[`FLOW_LOW_THRESHOLD_MSB:`FLOW_LOW_THRESHOLD_LSB];
		durCode = cfg_q[`AFC_DUR_MSB:`AFC_DUR_LSB];
		qualAny = cfg_q[`AFC_BIT_ANY];
		qualMcast = cfg_q[`AFC_BIT_MULT];
		qualBcast = cfg_q[`AFC_BIT_BRD];
		qualOwn = cfg_q[`AFC_BIT_ADDR];
	end

	// -----------------------------------------------------------------
	// Level compare and frame qualification
	// -----------------------------------------------------------------
	// The byte count is compared with the level shifted up, so a high level
	// of zero counts as always reached; software must program a real level.
	always_comb begin
		hiBytes = {hiLevel, {`AFC_UNIT_SHIFT{1'b0}}};
		loBytes = {loLevel, {`AFC_UNIT_SHIFT{1'b0}}};
		aboveHi = (rxFifoBytes >= hiBytes);
		belowLo = (rxFifoBytes < loBytes);
		anyEnabled = qualAny || qualMcast || qualBcast || qualOwn;
		if (qualAny) begin
			// Any-frame skips address decoding and reacts at the preamble.
			qualify = rxPreamble;
		end else begin
			qualify = rxAddrValid && ((qualMcast && rxMulticast)
				|| (qualBcast && rxBroadcast)
				|| (qualOwn && rxOwnAddress));
		end
		// Half duplex: qualifying frame above threshold starts a jam period.
		jamStart = txEnable && !fullDuplex && aboveHi && qualify;
	end

	// The timer restarts on every qualifying frame, so a burst of frames keeps
	// the partner held back until the period of the last one has run out.
	afc_jam_timer jamTimer (
		.mclk(mclk),
		.reset(reset),
		.start(jamStart),
		.durCode(durCode),
		.speed10(speed10),
		.busy(timerBusy)
	);

	// -----------------------------------------------------------------
	// Pause and jam control
	// -----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		pauseReq_d = pauseReq_q;
		pauseTime_d = pauseTime_q;
		pauseSent_d = pauseSent_q;
		// A request stands until the MAC takes it.
		if (pauseAck) begin
			pauseReq_d = 1'b0;
		end
		// Dropping the transmitter also withdraws a pause that is still waiting.
		if (!txEnable) begin
			pauseReq_d = 1'b0;
		end
		unique case (state_q)
			AFC_IDLE: begin
				// Only the any-frame bit arms pausing in full duplex.
				// A new request is set after the clear above, so it wins over an ack.
				if (txEnable && fullDuplex && cfg_q[`AFC_BIT_ANY] && aboveHi) begin
					pauseReq_d = 1'b1;
					pauseTime_d = pauseTimeValue;
					pauseSent_d = 1'b1;
					state_d = AFC_PAUSED;
				end else if (jamStart) begin
					state_d = AFC_JAMHOLD;
				end
			end
			AFC_PAUSED: begin
				// Exactly one pause per crossing; wait for drain below low level.
				if (belowLo) begin
					// A first pause still waiting for the MAC is not followed by a zero one.
					if (pauseSent_q && anyEnabled && txEnable && !pauseReq_q) begin
						pauseReq_d = 1'b1;
						pauseTime_d = 16'h0000;
					end
					// The flag clears even when the zero pause is withheld, so the next
					// crossing starts a fresh episode.
					pauseSent_d = 1'b0;
					state_d = AFC_IDLE;
				end
			end
			AFC_JAMHOLD: begin
				// The state only marks a running jam; the timer carries its length.
				if (!timerBusy && !jamStart) begin
					state_d = AFC_IDLE;
				end
			end
			default: begin
				// The unused code returns to idle rather than locking up.
				state_d = AFC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= AFC_IDLE;
			pauseReq_q <= 1'b0;
			pauseTime_q <= 16'h0000;
			pauseSent_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pauseReq_q <= pauseReq_d;
			pauseTime_q <= pauseTime_d;
			pauseSent_q <= pauseSent_d;
		end
	end

	// -----------------------------------------------------------------
	// Backpressure output
	// -----------------------------------------------------------------
	// The jam follows the start pulse at once so that the frame which
	// qualified is already held back; the timer only stretches it.
	always_comb begin
		jam_d = txEnable && !fullDuplex && (jamStart || timerBusy);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			jam_q <= 1'b0;
		end else begin
			jam_q <= jam_d;
		end
	end
endmodule : afc_flow_ctrl

/* File: logic/afc_regs.svh */
// Register offsets, field positions, reset values and timing counts for the flow controller.
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
`define AUTO_FLOW_CONTROL_CONFIG_OFFSET 8'hac
`define AUTO_FLOW_CONTROL_CONFIG_RESET 32'h0000_0000
`define AUTO_FLOW_CONTROL_CONFIG_WMASK 32'h00ff_ffff
`define FLOW_HIGH_THRESHOLD_MSB 23
`define FLOW_HIGH_THRESHOLD_LSB 16
`define FLOW_LOW_THRESHOLD_MSB 15
`define FLOW_LOW_THRESHOLD_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_BIT_MULT 3
`define AFC_BIT_BRD 2
`define AFC_BIT_ADDR 1
`define AFC_BIT_ANY 0
`define AFC_UNIT_SHIFT 6
`define AFC_CLK_MHZ 250
`define AFC_TENS_EXTRA_NS 2200
`define AFC_NS_PER_US 1000
`define AFC_DUR0_US 5
`define AFC_DUR1_US 10
`define AFC_DUR2_US 15
`define AFC_DUR3_US 25
`define AFC_DUR_STEP_US 50
`endif

/* File: logic/afc_pkg.sv */
// Types shared by the flow controller modules.
package afc_pkg;
	typedef enum logic [1:0] {
		AFC_IDLE = 2'b00,
		AFC_PAUSED = 2'b01,
		AFC_JAMHOLD = 2'b10
	} afc_state_e;
	typedef logic [19:0] afc_count_t;
endpackage : afc_pkg

/* File: logic/afc_jam_timer.sv */
// Backpressure duration timer: loads a period from a duration code and counts it down.
`timescale 1ns/1ps
`include "afc_regs.svh"
module afc_jam_timer import afc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic [3:0] durCode,
	input wire logic speed10,
	// Status
	output logic busy
);
	afc_count_t count_q, count_d;
	afc_count_t period;
	logic [31:0] periodUs;

	// -----------------------------------------------------------------
	// Duration lookup
	// -----------------------------------------------------------------
	always_comb begin
		unique case (durCode)
			4'h0: periodUs = `AFC_DUR0_US;
			4'h1: periodUs = `AFC_DUR1_US;
			4'h2: periodUs = `AFC_DUR2_US;
			4'h3: periodUs = `AFC_DUR3_US;
			default: periodUs = 32'(durCode - 4'h3) * `AFC_DUR_STEP_US;
		endcase
		// At 10 Mb/s each period grows by a fixed extra.
		period = afc_count_t'(periodUs * `AFC_CLK_MHZ
			+ (speed10 ? (`AFC_TENS_EXTRA_NS * `AFC_CLK_MHZ) / `AFC_NS_PER_US : 0));
		count_d = count_q;
		if (start) begin
			count_d = period;
		end else if (count_q != '0) begin
			count_d = count_q - afc_count_t'(1);
		end
		busy = (count_q != '0);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : afc_jam_timer

/* File: dv/afc_flow_checker.sv */
// Port assertions for the automatic flow controller.
`timescale 1ns/1ps
module afc_flow_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Watched ports
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic [31:0] regRdata_q,
	input wire logic txEnable,
	input wire logic fullDuplex,
	input wire logic [15:0] pauseTimeValue,
	input wire logic pauseReq_q,
	input wire logic [15:0] pauseTime_q,
	input wire logic pauseAck,
	input wire logic jam_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Saturating length of the current jam.
	logic [11:0] jamCnt_q;
	always_ff @(posedge mclk or posedge reset)
		if (reset) jamCnt_q <= 12'h0;
		else jamCnt_q <= jam_q ? jamCnt_q + {11'h0, ~&jamCnt_q} : 12'h0;
	sequence ackSeq;
		pauseReq_q && pauseAck;
	endsequence
	txoff_pause_a: assert property (!txEnable |=> !pauseReq_q) else $error("pause while tx off");
	txoff_jam_a: assert property ($rose(jam_q) |-> $past(txEnable)) else $error("jam while tx off");
	fd_jam_a: assert property ($rose(jam_q) |-> !$past(fullDuplex)) else $error("jam in full duplex");
	ack_drop_a: assert property (ackSeq |=> !pauseReq_q) else $error("request kept after ack");
	req_hold_a: assert property (pauseReq_q && !pauseAck && txEnable |=> pauseReq_q && $stable(pauseTime_q))
		else $error("request not held");
	pause_time_a: assert property ($rose(pauseReq_q) && pauseTime_q != 16'h0 |-> pauseTime_q == $past(pauseTimeValue))
		else $error("wrong pause time");
	jam_len_a: assert property ($fell(jam_q) && txEnable |-> jamCnt_q >= 12'd1250) else $error("jam too short");
	rd_unmap_a: assert property (regRead && regAddr != 8'hac |=> regRdata_q == 32'h0) else $error("unmapped read");
	rd_top_a: assert property (regRead |=> regRdata_q[31:24] == 8'h0) else $error("reserved bits set");
	rd_hold_a: assert property (!regRead |=> $stable(regRdata_q)) else $error("read data moved");
endmodule : afc_flow_checker
bind afc_flow_ctrl afc_flow_checker chk (.*);

/* File: dv/afc_mac_model.sv */
// MAC transmit side that grants pause requests after a short or long wait.
`timescale 1ns/1ps
module afc_mac_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Request and grant
	input wire logic pauseReq,
	input wire logic slow,
	output logic pauseAck
);
	logic [3:0] waitQ;
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			waitQ <= 4'h0;
			pauseAck <= 1'b0;
		end else begin
			pauseAck <= 1'b0;
			if (pauseReq && !pauseAck) begin
				waitQ <= waitQ + 4'h1;
				if (waitQ == (slow ? 4'h9 : 4'h1)) begin
					pauseAck <= 1'b1;
					waitQ <= 4'h0;
				end
			end else if (!pauseReq) begin
				waitQ <= 4'h0;
			end
		end
	end
endmodule : afc_mac_model

/* File: dv/rx_fifo_flow_control_test.sv */
// Self-checking bench for the automatic flow controller.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t got %h expected %h", $time, a, b); end end
module rx_fifo_flow_control_test;
	logic mclk = 0, reset = 1, regWrite = 0, regRead = 0, txEnable = 1, fullDuplex = 1;
	logic speed10 = 0, rxPreamble = 0, rxAddrValid = 0, rxMulticast = 0, rxBroadcast = 0;
	logic rxOwnAddress = 0, slowAck = 0, pauseReq_q, pauseAck, jam_q;
	logic [7:0] regAddr = 0;
	logic [31:0] regWdata = 0, regRdata_q;
	logic [15:0] pauseTimeValue = 16'h1234, pauseTime_q;
	logic [13:0] rxFifoBytes = 0;
	int mismatches = 0, compares = 0, n;
	always #2 mclk = ~mclk;
	afc_flow_ctrl DUT (.*);
	afc_mac_model partner (.mclk, .reset, .pauseReq(pauseReq_q), .slow(slowAck), .pauseAck);
	task automatic step(int k); repeat (k) @(posedge mclk); #1; endtask : step
	task automatic wr(logic [31:0] d);
		regAddr = 8'hac; regWdata = d; regWrite = 1; step(1); regWrite = 0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		regAddr = a; regRead = 1; step(1); regRead = 0; `CHK(regRdata_q, e)
	endtask : rd
	task automatic waitReq(logic [15:0] t);
		n = 0;
		while (pauseReq_q !== 1'b1 && n < 50) begin step(1); n++; end
		`CHK({pauseReq_q, pauseTime_q}, {1'b1, t})
		step(30); `CHK(pauseReq_q, 1'b0)
	endtask : waitReq
	// Sends one frame and counts the cycles of jamming that follow it.
	task automatic frame(logic [31:0] cfg, logic [2:0] ind, int exp);
		wr(cfg); n = 0; rxPreamble = 1; step(1); rxPreamble = 0; rxAddrValid = 1;
		{rxMulticast, rxBroadcast, rxOwnAddress} = ind; n += jam_q; step(1);
		rxAddrValid = 0; {rxMulticast, rxBroadcast, rxOwnAddress} = 3'h0;
		while (jam_q === 1'b1 && n < 9000) begin n++; step(1); end
		`CHK(n, exp)
	endtask : frame
	task automatic complete_run;
		if (mismatches == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		step(12); reset = 0; step(1);
		rd(8'hac, 32'h0);
		wr(32'hffff_feff); rd(8'hac, 32'h00ff_feff);
		rd(8'ha8, 32'h0);
		wr(32'h0002_0101); rxFifoBytes = 14'd127; step(20); `CHK(pauseReq_q, 1'b0)
		txEnable = 0; rxFifoBytes = 14'd128; step(20); `CHK(pauseReq_q, 1'b0)
		rxFifoBytes = 14'd127; step(2); txEnable = 1; step(2);
		rxFifoBytes = 14'd128; waitReq(16'h1234);
		rxFifoBytes = 14'd64; step(20); `CHK(pauseReq_q, 1'b0)
		rxFifoBytes = 14'd63; waitReq(16'h0);
		slowAck = 1; rxFifoBytes = 14'd200; waitReq(16'h1234);
		rxFifoBytes = 14'd0; waitReq(16'h0);
		slowAck = 0; fullDuplex = 0; rxFifoBytes = 14'd200;
		frame(32'h0002_0101, 3'b000, 1251);
		frame(32'h0002_0112, 3'b001, 2501);
		frame(32'h0002_0124, 3'b010, 3751);
		frame(32'h0002_0138, 3'b100, 6251);
		frame(32'h0002_0108, 3'b010, 0);
		txEnable = 0; frame(32'h0002_0101, 3'b000, 0); txEnable = 1;
		speed10 = 1; frame(32'h0002_0101, 3'b000, 1801);
		complete_run;
	end
	initial begin
		step(40000); mismatches++; complete_run;
	end
endmodule : rx_fifo_flow_control_test
